/* File: hw/rfcfg_pkg.sv */
/*
  Constants shared by the front-end configuration register bank:
  register indices, byte addresses, field positions, reset values,
  bus response codes and the receiver gain figures.
  Assumes the including modules run on one clock with AXI4-Lite access.
*/
package rfcfg_pkg;

  // ------------------------------------------------------------------
  // Register indices and byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] RFCFG_IDX_RX_GAIN = 8'h26;
  localparam logic [7:0] RFCFG_IDX_N_DRIVE = 8'h27;
  localparam logic [7:0] RFCFG_IDX_P_IDLE = 8'h28;
  localparam logic [7:0] RFCFG_IDX_P_MOD = 8'h29;
  localparam logic [7:0] RFCFG_IDX_MODE_CTRL = 8'h30;
  localparam logic [7:0] RFCFG_IDX_DRIVE_STATUS = 8'h31;
  localparam int RFCFG_BYTES_PER_REG = 4;
  localparam int RFCFG_ADDR_LSB = 2;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int RFCFG_GAIN_LSB = 4;
  localparam int RFCFG_GAIN_W = 3;
  localparam int RFCFG_N_IDLE_LSB = 4;
  localparam int RFCFG_N_MOD_LSB = 0;
  localparam int RFCFG_N_W = 4;
  localparam int RFCFG_P_W = 6;
  localparam int RFCFG_CTRL_PDOWN_BIT = 0;
  localparam int RFCFG_CTRL_FULL_ASK_BIT = 1;
  localparam int RFCFG_STAT_N_LSB = 0;
  localparam int RFCFG_STAT_P_LSB = 4;
  localparam int RFCFG_STAT_MOD_BIT = 10;
  localparam int RFCFG_STAT_DRV_BIT = 11;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RFCFG_RST_RX_GAIN = 8'h48;
  localparam logic [7:0] RFCFG_RST_N_DRIVE = 8'h88;
  localparam logic [7:0] RFCFG_RST_P_IDLE = 8'h20;
  localparam logic [7:0] RFCFG_RST_P_MOD = 8'h20;
  localparam logic [1:0] RFCFG_RST_MODE_CTRL = 2'h0;

  // ------------------------------------------------------------------
  // Bus responses
  // ------------------------------------------------------------------
  localparam logic [1:0] RFCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] RFCFG_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Receiver gain in dB
  // ------------------------------------------------------------------
  localparam logic [5:0] RFCFG_GAIN_DB_18 = 6'h12;
  localparam logic [5:0] RFCFG_GAIN_DB_23 = 6'h17;
  localparam logic [5:0] RFCFG_GAIN_DB_33 = 6'h21;
  localparam logic [5:0] RFCFG_GAIN_DB_38 = 6'h26;
  localparam logic [5:0] RFCFG_GAIN_DB_43 = 6'h2b;
  localparam logic [5:0] RFCFG_GAIN_DB_48 = 6'h30;

endpackage

/* File: hw/rfcfg_drive_select.sv */
/*
  Picks the live conductance for one antenna driver half from its idle
  and modulation fields, with power-down and ignore overrides.
  Assumes purely combinational use; the caller registers the result.
*/
`timescale 1ns/10ps
`default_nettype none

module rfcfg_drive_select #(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] idle_level,
  input wire logic [WIDTH-1:0] mod_level,
  input wire logic modulating,
  input wire logic drivers_on,
  input wire logic power_down,
  input wire logic mod_ignore,
  output logic [WIDTH-1:0] level
);

  // ------------------------------------------------------------------
  // Selection
  // ------------------------------------------------------------------
  // Result stays a binary weight: bit i drives a segment worth 2^i
  always_comb
  begin
    level = modulating ? mod_level : idle_level;
    if (power_down)
    begin
      level[WIDTH-1] = 1'b1;
    end
    if (modulating && mod_ignore)
    begin
      level = '0;
    end
    if (!drivers_on)
    begin
      level = '0;
    end
  end

endmodule

`default_nettype wire

/* File: hw/rfcfg_regs.sv */
/*
  Analogue front-end configuration register bank: receiver gain,
  N-driver and P-driver conductance settings behind an AXI4-Lite slave,
  with the live settings driven out to the analogue front end.
  Assumes one clock, inputs synchronous to it, and a master that keeps
  at most one write and one read under way.
*/
// Summary of operation
// - Gain code picks 18 to 48 dB
// - Gain register bits 7, 3..0 reserved
// - N-driver upper nibble sets idle conductance
// - N-driver lower nibble sets modulation conductance
// - N settings used only with driver on
// - Conductance fields are binary weighted
// - Power-down forces each field's top bit, except N with both drivers off and P under full ASK modulation
// - P idle register: low six bits
// - P modulation register: low six bits
// - Full ASK makes P modulation field unused
`timescale 1ns/10ps
`default_nettype none

module rfcfg_regs
  import rfcfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmitter state
  input wire logic antenna_out_one,
  input wire logic antenna_out_two,
  input wire logic modulation_active,
  // Live settings to the analogue front end
  output logic [RFCFG_GAIN_W-1:0] receiver_gain_select,
  output logic [5:0] receiver_gain_db,
  output logic [RFCFG_N_W-1:0] n_drive_conductance,
  output logic [RFCFG_P_W-1:0] p_drive_conductance,
  output logic soft_power_down,
  output logic full_ask_force
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [RFCFG_GAIN_W-1:0] gain;
    logic [RFCFG_N_W-1:0] n_idle;
    logic [RFCFG_N_W-1:0] n_mod;
    logic [RFCFG_P_W-1:0] p_idle;
    logic [RFCFG_P_W-1:0] p_mod;
    logic pdown;
    logic full_ask;
    logic [5:0] gain_db;
    logic [RFCFG_N_W-1:0] n_live;
    logic [RFCFG_P_W-1:0] p_live;
  } rfcfg_state_t;

  rfcfg_state_t state_reg;
  rfcfg_state_t state_next;
  logic drivers_on;
  logic [RFCFG_N_W-1:0] n_pick;
  logic [RFCFG_P_W-1:0] p_pick;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Word index of a byte address; low bits ignored, accesses are whole words
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr) >> RFCFG_ADDR_LSB;
    return wide[7:0];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = word_index(addr);
    return (idx == RFCFG_IDX_RX_GAIN) || (idx == RFCFG_IDX_N_DRIVE) ||
      (idx == RFCFG_IDX_P_IDLE) || (idx == RFCFG_IDX_P_MOD) ||
      (idx == RFCFG_IDX_MODE_CTRL) || (idx == RFCFG_IDX_DRIVE_STATUS);
  endfunction

  // Codes 000/010 and 001/011 alias; bit 1 only matters with bit 2 set
  function automatic logic [5:0] gain_in_db(input logic [RFCFG_GAIN_W-1:0] code);
    logic [5:0] db;
    case (code)
      3'h0, 3'h2: db = RFCFG_GAIN_DB_18;
      3'h1, 3'h3: db = RFCFG_GAIN_DB_23;
      3'h4: db = RFCFG_GAIN_DB_33;
      3'h5: db = RFCFG_GAIN_DB_38;
      3'h6: db = RFCFG_GAIN_DB_43;
      default: db = RFCFG_GAIN_DB_48;
    endcase
    return db;
  endfunction

  // ------------------------------------------------------------------
  // Driver selection
  // ------------------------------------------------------------------
  assign drivers_on = antenna_out_one || antenna_out_two;

  rfcfg_drive_select #(
    .WIDTH(RFCFG_N_W)
  ) u_n_select (
    .idle_level(state_reg.n_idle),
    .mod_level(state_reg.n_mod),
    .modulating(modulation_active),
    .drivers_on(drivers_on),
    .power_down(state_reg.pdown),
    .mod_ignore(1'b0),
    .level(n_pick)
  );

  // P side has no driver-on gate of its own; full ASK drops its mod field
  rfcfg_drive_select #(
    .WIDTH(RFCFG_P_W)
  ) u_p_select (
    .idle_level(state_reg.p_idle),
    .mod_level(state_reg.p_mod),
    .modulating(modulation_active),
    .drivers_on(1'b1),
    .power_down(state_reg.pdown),
    .mod_ignore(state_reg.full_ask),
    .level(p_pick)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] idx;
    logic [31:0] rd;
    idx = 8'h00;
    rd = 32'h0000_0000;
    state_next = state_reg;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && state_reg.awready)
    begin
      state_next.aw_full = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready)
    begin
      state_next.w_full = 1'b1;
      state_next.wdata = s_axi_wdata[7:0];
      state_next.wlane0 = s_axi_wstrb[0];
    end
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end

    // Commit once both halves are held and the last answer is gone
    if (state_next.aw_full && state_next.w_full && !state_next.bvalid)
    begin
      idx = word_index(state_next.awaddr);
      state_next.aw_full = 1'b0;
      state_next.w_full = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = mapped(state_next.awaddr) ? RFCFG_RESP_OKAY : RFCFG_RESP_SLVERR;
      // Registers are one byte wide, so only lane 0 can change them
      if (state_next.wlane0)
      begin
        case (idx)
          RFCFG_IDX_RX_GAIN:
          begin
            state_next.gain = state_next.wdata[RFCFG_GAIN_LSB +: RFCFG_GAIN_W];
          end
          RFCFG_IDX_N_DRIVE:
          begin
            state_next.n_idle = state_next.wdata[RFCFG_N_IDLE_LSB +: RFCFG_N_W];
            state_next.n_mod = state_next.wdata[RFCFG_N_MOD_LSB +: RFCFG_N_W];
          end
          RFCFG_IDX_P_IDLE:
          begin
            state_next.p_idle = state_next.wdata[RFCFG_P_W-1:0];
          end
          RFCFG_IDX_P_MOD:
          begin
            state_next.p_mod = state_next.wdata[RFCFG_P_W-1:0];
          end
          RFCFG_IDX_MODE_CTRL:
          begin
            state_next.pdown = state_next.wdata[RFCFG_CTRL_PDOWN_BIT];
            state_next.full_ask = state_next.wdata[RFCFG_CTRL_FULL_ASK_BIT];
          end
          default:
          begin
            state_next.bresp = state_next.bresp; // Unmapped or read-only: no store
          end
        endcase
      end
    end
    state_next.awready = !state_next.aw_full;
    state_next.wready = !state_next.w_full;

    // Read: one outstanding; arready drops until the data is taken
    if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
    if (s_axi_arvalid && state_reg.arready)
    begin
      idx = word_index(s_axi_araddr);
      case (idx)
        RFCFG_IDX_RX_GAIN:
        begin
          rd[RFCFG_GAIN_LSB +: RFCFG_GAIN_W] = state_reg.gain;
        end
        RFCFG_IDX_N_DRIVE:
        begin
          rd[RFCFG_N_IDLE_LSB +: RFCFG_N_W] = state_reg.n_idle;
          rd[RFCFG_N_MOD_LSB +: RFCFG_N_W] = state_reg.n_mod;
        end
        RFCFG_IDX_P_IDLE:
        begin
          rd[RFCFG_P_W-1:0] = state_reg.p_idle;
        end
        RFCFG_IDX_P_MOD:
        begin
          rd[RFCFG_P_W-1:0] = state_reg.p_mod;
        end
        RFCFG_IDX_MODE_CTRL:
        begin
          rd[RFCFG_CTRL_PDOWN_BIT] = state_reg.pdown;
          rd[RFCFG_CTRL_FULL_ASK_BIT] = state_reg.full_ask;
        end
        RFCFG_IDX_DRIVE_STATUS:
        begin
          rd[RFCFG_STAT_N_LSB +: RFCFG_N_W] = state_reg.n_live;
          rd[RFCFG_STAT_P_LSB +: RFCFG_P_W] = state_reg.p_live;
          rd[RFCFG_STAT_MOD_BIT] = modulation_active;
          rd[RFCFG_STAT_DRV_BIT] = drivers_on;
        end
        default:
        begin
          rd = 32'h0000_0000;
        end
      endcase
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rdata = rd;
      state_next.rresp = mapped(s_axi_araddr) ? RFCFG_RESP_OKAY : RFCFG_RESP_SLVERR;
    end

    // Live settings follow the fields and transmitter state by one cycle
    state_next.gain_db = gain_in_db(state_reg.gain);
    state_next.n_live = n_pick;
    state_next.p_live = p_pick;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.gain <= RFCFG_RST_RX_GAIN[RFCFG_GAIN_LSB +: RFCFG_GAIN_W];
      state_reg.n_idle <= RFCFG_RST_N_DRIVE[RFCFG_N_IDLE_LSB +: RFCFG_N_W];
      state_reg.n_mod <= RFCFG_RST_N_DRIVE[RFCFG_N_MOD_LSB +: RFCFG_N_W];
      state_reg.p_idle <= RFCFG_RST_P_IDLE[RFCFG_P_W-1:0];
      state_reg.p_mod <= RFCFG_RST_P_MOD[RFCFG_P_W-1:0];
      state_reg.pdown <= RFCFG_RST_MODE_CTRL[RFCFG_CTRL_PDOWN_BIT];
      state_reg.full_ask <= RFCFG_RST_MODE_CTRL[RFCFG_CTRL_FULL_ASK_BIT];
      state_reg.gain_db <= RFCFG_GAIN_DB_33;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign receiver_gain_select = state_reg.gain;
  assign receiver_gain_db = state_reg.gain_db;
  assign n_drive_conductance = state_reg.n_live;
  assign p_drive_conductance = state_reg.p_live;
  assign soft_power_down = state_reg.pdown;
  assign full_ask_force = state_reg.full_ask;

endmodule

`default_nettype wire

/* File: tb/rfcfg_monitor.sv */
/*
  Concurrent checks on the front-end configuration register bank ports.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module rfcfg_monitor
  import rfcfg_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic antenna_out_one,
  input wire logic antenna_out_two,
  input wire logic modulation_active,
  input wire logic [2:0] receiver_gain_select,
  input wire logic [5:0] receiver_gain_db,
  input wire logic [3:0] n_drive_conductance,
  input wire logic [5:0] p_drive_conductance,
  input wire logic soft_power_down,
  input wire logic full_ask_force
);
  logic [5:0] db_exp_reg;
  logic [5:0] db_exp_next;

  // Gain figure expected one cycle after the code
  always_comb
  begin
    case (receiver_gain_select)
      3'h0, 3'h2: db_exp_next = RFCFG_GAIN_DB_18;
      3'h1, 3'h3: db_exp_next = RFCFG_GAIN_DB_23;
      3'h4: db_exp_next = RFCFG_GAIN_DB_33;
      3'h5: db_exp_next = RFCFG_GAIN_DB_38;
      3'h6: db_exp_next = RFCFG_GAIN_DB_43;
      default: db_exp_next = RFCFG_GAIN_DB_48;
    endcase
  end

  // Reset value matches the reset gain code
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      db_exp_reg <= RFCFG_GAIN_DB_33;
    else
      db_exp_reg <= db_exp_next;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_gain_db_map: assert property (receiver_gain_db == db_exp_reg)
    else $error("gain figure does not follow the gain code");
  a_n_drivers_off: assert property ((!antenna_out_one && !antenna_out_two && !soft_power_down) |=>
    (n_drive_conductance == 4'h0)) else $error("N conductance live with both drivers off");
  a_n_pdown_msb: assert property ((soft_power_down && (antenna_out_one || antenna_out_two)) |=>
    n_drive_conductance[3]) else $error("N top bit not forced in power-down");
  a_p_pdown_msb: assert property ((soft_power_down && !(full_ask_force && modulation_active)) |=>
    p_drive_conductance[5]) else $error("P top bit not forced in power-down");
  a_p_full_ask: assert property ((full_ask_force && modulation_active && !soft_power_down) |=>
    (p_drive_conductance == 6'h0)) else $error("P modulation field used under full ASK");
  a_rdata_upper: assert property (s_axi_rvalid |-> (s_axi_rdata[31:12] == 20'h0))
    else $error("unused read data bits not zero");
  a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property ((s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read answer dropped or changed");
  a_bvalid_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write answer dropped or changed");
endmodule

bind rfcfg_regs rfcfg_monitor mon (.clock, .reset_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .antenna_out_one,
  .antenna_out_two, .modulation_active, .receiver_gain_select, .receiver_gain_db,
  .n_drive_conductance, .p_drive_conductance, .soft_power_down, .full_ask_force);

`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking bench for the front-end configuration register bank.
  Assumes the bound monitor and a lone AXI4-Lite master in this bench.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import rfcfg_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0, n_drive_conductance;
  logic antenna_out_one = 0, antenna_out_two = 0, modulation_active = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, soft_power_down, full_ask_force;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] receiver_gain_select;
  logic [5:0] receiver_gain_db, p_drive_conductance;
  logic [33:0] rq[$], bq[$];
  logic [7:0] msk[4] = '{8'h70, 8'hff, 8'h3f, 8'h3f};
  logic [5:0] db_tab[8] = '{6'h12, 6'h17, 6'h12, 6'h17, 6'h21, 6'h26, 6'h2b, 6'h30};
  int n_fail = 0, compares = 0, cycles = 0;

  always #4 clock = ~clock;

  rfcfg_regs dut (.clock, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .antenna_out_one, .antenna_out_two, .modulation_active,
    .receiver_gain_select, .receiver_gain_db, .n_drive_conductance, .p_drive_conductance,
    .soft_power_down, .full_ask_force);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Answer is taken one edge late so the hold of bvalid is exercised
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] rsp);
    bq.push_back({rsp, 32'h0});
    @(posedge clock);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clock);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask

  // Answers are compared against the oldest note as each is taken
  always @(posedge clock)
  begin
    cycles++;
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d, ix;
    logic [4:0] v;
    logic [3:0] nx;
    logic [5:0] px;
    void'($urandom(32'hd75d));
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd(8'h26, {2'h0, 32'h40});
    rd(8'h27, {2'h0, 32'h88});
    rd(8'h28, {2'h0, 32'h20});
    rd(8'h29, {2'h0, 32'h20});
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      ix = 8'h26 + 8'(i % 4);
      wr(ix, d, 4'h1, RFCFG_RESP_OKAY);
      rd(ix, {RFCFG_RESP_OKAY, 24'h0, d & msk[i % 4]});
    end
    // Cleared strobe and unmapped place leave the bank alone
    wr(8'h27, 8'h5a, 4'h1, RFCFG_RESP_OKAY);
    wr(8'h27, 8'ha5, 4'h0, RFCFG_RESP_OKAY);
    rd(8'h27, {RFCFG_RESP_OKAY, 32'h5a});
    wr(8'h20, 8'hff, 4'h1, RFCFG_RESP_SLVERR);
    rd(8'h20, {RFCFG_RESP_SLVERR, 32'h0});
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h26, {1'b1, 3'(c), 4'hf}, 4'h1, RFCFG_RESP_OKAY);
      repeat (3) @(posedge clock);
      chk({28'h0, receiver_gain_db}, {28'h0, db_tab[c]});
      chk({31'h0, receiver_gain_select}, {31'h0, 3'(c)});
    end
    // Live drive levels over mode and transmitter states; power-down only with a driver on and no full ASK modulation
    wr(8'h27, 8'h35, 4'h1, RFCFG_RESP_OKAY);
    wr(8'h28, 8'h11, 4'h1, RFCFG_RESP_OKAY);
    wr(8'h29, 8'h0a, 4'h1, RFCFG_RESP_OKAY);
    for (int k = 0; k < 32; k++)
    begin
      v = 5'(k);
      if (v[4] && (!(v[1] || v[2]) || (v[3] && v[0])))
        continue;
      wr(8'h30, {6'h0, v[3], v[4]}, 4'h1, RFCFG_RESP_OKAY);
      @(posedge clock);
      modulation_active <= v[0];
      antenna_out_one <= v[1];
      antenna_out_two <= v[2];
      nx = (v[1] || v[2]) ? ((v[0] ? 4'h5 : 4'h3) | {v[4], 3'h0}) : 4'h0;
      px = (v[3] && v[0]) ? 6'h0 : ((v[0] ? 6'h0a : 6'h11) | {v[4], 5'h0});
      rd(8'h31, {RFCFG_RESP_OKAY, 20'h0, v[1] | v[2], v[0], px, nx});
      // Live pins and mode outputs settled well before this edge
      chk({22'h0, full_ask_force, soft_power_down, p_drive_conductance, n_drive_conductance}, {22'h0, v[3], v[4], px, nx});
    end
    conclude();
  end
endmodule

`default_nettype wire
